// [hdl/fpc_page_buf.sv]
// two banks of page register storage: one port for the host side, one for
// the array side, a single shared write port.
// assumes the caller never writes one entry from two sources at once.
`default_nettype none

module fpc_page_buf #(
    parameter int PAGE_BYTES = 256
) (
    input wire logic clk, // system clock
    input wire logic wr_en, // write strobe
    input wire logic wr_bank, // bank written
    input wire logic [$clog2(PAGE_BYTES)-1:0] wr_addr, // column written
    input wire logic [7:0] wr_data, // byte written
    input wire logic ha_bank, // host read bank
    input wire logic [$clog2(PAGE_BYTES)-1:0] ha_addr, // host read column
    output logic [7:0] ha_data, // host read byte, one cycle later
    input wire logic aa_bank, // array read bank
    input wire logic [$clog2(PAGE_BYTES)-1:0] aa_addr, // array read column
    output logic [7:0] aa_data // array read byte, one cycle later
);
    localparam int AW = $clog2(PAGE_BYTES);
    logic [7:0] mem [0:2*PAGE_BYTES-1];

    // storage has no reset; contents are defined by host load, clear or array fetch
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[{wr_bank, wr_addr}] <= wr_data;
        end
        ha_data <= mem[{ha_bank, ha_addr}];
        aa_data <= mem[{aa_bank, aa_addr}];
    end

    // refused at elaboration: the column counters need at least two address bits
    if (AW < 2) begin : g_size_chk
        $error("page too small");
    end
endmodule

`default_nettype wire

// [hdl/fpc_pkg.sv]
// types shared by the sequencer files: controller states and pending ops.
// assumes the constants header is compiled alongside.
`default_nettype none

package fpc_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_RDCF, S_CLEAR, S_LOAD, S_RCOL_CF, S_WAIT, S_BUSY, S_FLUSH
    } fpc_state_t;
    typedef enum logic [2:0] {OP_PROG, OP_ALT, OP_READ, OP_RCOL} fpc_op_t;
    typedef enum logic [1:0] {PEND_FINAL, PEND_CACHE, PEND_READ} fpc_pend_t;
endpackage

`default_nettype wire

// [hdl/fpc_program_seq.sv]
// program-side command sequencer of one flash logical unit: page program,
// cache program, copyback, small data moves and read column change.
// assumes host cycles arrive decoded and synchronous to clk; the array
// engine outside walks arr_addr itself and answers each request with arr_done.
`include "fpc_regs.svh"
`default_nettype none

module fpc_program_seq import fpc_pkg::*; #(
    parameter int PAGE_BYTES = 256
) (
    input wire logic clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic cmd_valid, // command cycle strobe
    input wire logic [7:0] cmd_code, // command opcode
    input wire logic addr_valid, // address cycle strobe
    input wire logic [7:0] addr_byte, // address byte
    input wire logic din_valid, // data input strobe
    input wire logic [7:0] din, // data input byte
    output logic load_ready, // data input is taken
    input wire logic dout_req, // data output request
    output logic [7:0] dout_data, // data output byte
    output logic dout_valid, // data output byte valid
    input wire logic wp_n_pin, // write protect pin, low only clears status bit 7
    output logic [7:0] status_byte, // status byte, registered
    output logic arr_req, // array operation start pulse
    output logic arr_is_prog, // array op is program, else read
    output logic [23:0] arr_row, // array row address
    input wire logic [$clog2(PAGE_BYTES)-1:0] arr_addr, // array walk column
    output logic [7:0] arr_rdata, // page byte for array, one cycle later
    input wire logic arr_we, // array read writes page byte
    input wire logic [7:0] arr_wdata, // byte fetched from array
    input wire logic arr_done, // array operation end pulse
    input wire logic arr_fail, // array operation failed, with done
    input wire logic [3:0] reg_addr, // register offset
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_we, // register write strobe
    input wire logic reg_re, // register read strobe
    output logic [31:0] reg_rdata // register read data, next cycle
);
    localparam int AW = $clog2(PAGE_BYTES);

    fpc_state_t state_q, state_d;
    fpc_op_t op_q, op_d;
    fpc_pend_t pend_q, pend_d;
    logic [2:0] acnt_q, acnt_d, fcnt_q, fcnt_d;
    logic [15:0] cacc_q, cacc_d;
    logic [23:0] row_q, row_d, arow_q, arow_d;
    logic [AW-1:0] col_q, col_d, rcol_q, rcol_d, clr_q, clr_d;
    logic hbank_q, hbank_d, abank_q, abank_d;
    logic rdcond_q, rdcond_d, dval_q, dval_d;
    logic abusy_q, abusy_d, aprog_q, aprog_d, areq_q, areq_d;
    logic fail_q, fail_d, prior_op_failed_q, prior_op_failed_d, first_q, first_d, cseq_q, cseq_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] sb_q, sb_d;
    logic wp_m_q, wp_q;
    logic wr_en, rdy, array_idle;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data, hdata;

    // write protect comes from a pin: two flops before any use
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_m_q <= 1'b0;
            wp_q <= 1'b0;
        end else begin
            wp_m_q <= wp_n_pin;
            wp_q <= wp_m_q;
        end
    end

    assign rdy = !(state_q inside {S_WAIT, S_BUSY, S_FLUSH});
    assign array_idle = !abusy_q;
    assign load_ready = (state_q == S_LOAD);

    // shared write port: array fetch, then clear, then host load
    always_comb begin
        wr_en = 1'b0;
        wr_addr = col_q;
        wr_data = din;
        if (state_q == S_BUSY && pend_q == PEND_READ && arr_we) begin
            wr_en = 1'b1;
            wr_addr = arr_addr;
            wr_data = arr_wdata;
        end else if (state_q == S_CLEAR) begin
            wr_en = 1'b1;
            wr_addr = clr_q;
            wr_data = `FPC_CLEAR_BYTE;
        end else if (state_q == S_LOAD && din_valid) begin
            wr_en = 1'b1;
        end
    end

    // the host always writes its own bank, the array reads its own
    fpc_page_buf #(.PAGE_BYTES(PAGE_BYTES)) u_buf (
        .clk(clk),
        .wr_en(wr_en),
        .wr_bank(hbank_q),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .ha_bank(hbank_q),
        .ha_addr(rcol_q),
        .ha_data(hdata),
        .aa_bank(abank_q),
        .aa_addr(arr_addr),
        .aa_data(arr_rdata)
    );

    // command sequencing and array status next values
    always_comb begin
        state_d = state_q; op_d = op_q; pend_d = pend_q;
        acnt_d = acnt_q; fcnt_d = fcnt_q; cacc_d = cacc_q;
        row_d = row_q; arow_d = arow_q; col_d = col_q; rcol_d = rcol_q; clr_d = clr_q;
        hbank_d = hbank_q; abank_d = abank_q; rdcond_d = rdcond_q;
        abusy_d = abusy_q; aprog_d = aprog_q; areq_d = 1'b0; dval_d = 1'b0;
        fail_d = fail_q; prior_op_failed_d = prior_op_failed_q; first_d = first_q; cseq_d = cseq_q;
        case (state_q)
            S_IDLE, S_LOAD: begin
                if (cmd_valid) begin
                    acnt_d = 3'h0;
                    case (cmd_code)
                        `FPC_CMD_PROG: begin
                            op_d = OP_PROG; state_d = S_ADDR; rdcond_d = 1'b0;
                        end
                        `FPC_CMD_PROG_ALT: begin
                            op_d = OP_ALT; state_d = S_ADDR; rdcond_d = 1'b0;
                        end
                        `FPC_CMD_READ: begin
                            op_d = OP_READ; state_d = S_ADDR; rdcond_d = 1'b0;
                        end
                        `FPC_CMD_RCOL: begin
                            if (rdcond_q) begin
                                op_d = OP_RCOL; state_d = S_ADDR;
                            end
                        end
                        `FPC_CMD_CONFIRM: begin
                            if (state_q == S_LOAD) begin
                                pend_d = PEND_FINAL; state_d = S_WAIT;
                            end
                        end
                        `FPC_CMD_CACHE: begin
                            if (state_q == S_LOAD) begin
                                pend_d = ctrl_q[`FPC_CTRL_CACHE_BIT] ? PEND_CACHE : PEND_FINAL;
                                state_d = S_WAIT;
                            end
                        end
                        `FPC_CMD_FLUSH: begin
                            if (state_q == S_LOAD && ctrl_q[`FPC_CTRL_SMALL_BIT]) begin
                                state_d = S_FLUSH; fcnt_d = `FPC_FLUSH_CYC - 3'h1;
                            end
                        end
                        default: ;
                    endcase
                end else if (state_q == S_LOAD && din_valid) begin
                    col_d = col_q + 1'b1;
                end else if (state_q == S_IDLE && rdcond_q && dout_req) begin
                    rcol_d = rcol_q + 1'b1;
                    dval_d = 1'b1;
                end
            end
            S_ADDR: begin
                if (addr_valid) begin
                    acnt_d = acnt_q + 3'h1;
                    case (acnt_q)
                        3'h0: cacc_d[7:0] = addr_byte;
                        3'h1: cacc_d[15:8] = addr_byte;
                        3'h2: row_d[7:0] = addr_byte;
                        3'h3: row_d[15:8] = addr_byte;
                        default: row_d[23:16] = addr_byte;
                    endcase
                    if (op_q == OP_RCOL && acnt_q == `FPC_RCOL_LAST) begin
                        state_d = S_RCOL_CF;
                    end else if (op_q != OP_RCOL && acnt_q == `FPC_ADDR_LAST) begin
                        col_d = cacc_q[AW-1:0];
                        clr_d = '0;
                        if (op_q == OP_READ) begin
                            state_d = S_RDCF;
                        end else if (op_q == OP_PROG && ctrl_q[`FPC_CTRL_CLR_BIT]) begin
                            state_d = S_CLEAR;
                        end else begin
                            state_d = S_LOAD;
                        end
                    end
                end
            end
            S_RDCF: begin
                if (cmd_valid) begin
                    pend_d = PEND_READ;
                    state_d = (cmd_code == `FPC_CMD_CB_READ) ? S_WAIT : S_IDLE;
                end
            end
            S_CLEAR: begin
                clr_d = clr_q + 1'b1;
                if (clr_q == AW'(PAGE_BYTES - 1)) begin
                    state_d = S_LOAD;
                end
            end
            S_RCOL_CF: begin
                if (cmd_valid) begin
                    state_d = S_IDLE;
                    if (cmd_code == `FPC_CMD_RCOL_CF) begin
                        rcol_d = cacc_q[AW-1:0];
                    end
                end
            end
            S_WAIT: begin
                // the previous page must leave the array first
                if (!abusy_q) begin
                    areq_d = 1'b1;
                    aprog_d = (pend_q != PEND_READ);
                    arow_d = row_q;
                    abank_d = hbank_q;
                    if (pend_q == PEND_CACHE) begin
                        hbank_d = !hbank_q;
                        first_d = !cseq_q;
                        cseq_d = 1'b1;
                        state_d = S_IDLE;
                    end else begin
                        if (pend_q == PEND_FINAL) begin
                            first_d = !cseq_q;
                            cseq_d = 1'b0;
                        end
                        state_d = S_BUSY;
                    end
                end
            end
            S_BUSY: begin
                if (arr_done) begin
                    state_d = S_IDLE;
                    if (pend_q == PEND_READ) begin
                        rdcond_d = 1'b1;
                        rcol_d = col_q;
                    end
                end
            end
            S_FLUSH: begin
                fcnt_d = fcnt_q - 3'h1;
                if (fcnt_q == 3'h0) begin
                    state_d = S_IDLE;
                    rdcond_d = 1'b1;
                end
            end
            default: state_d = S_IDLE;
        endcase
        // array bookkeeping; a request is only made while the array is idle
        if (areq_d) begin
            abusy_d = 1'b1;
        end else if (arr_done) begin
            abusy_d = 1'b0;
        end
        if (arr_done && abusy_q && aprog_q) begin
            fail_d = arr_fail;
            prior_op_failed_d = fail_q;
        end
    end

    // status byte: bits 5:0 are forced low while not ready
    always_comb begin
        sb_d = 8'h00;
        sb_d[`FPC_SB_WP] = wp_q;
        sb_d[`FPC_SB_RDY] = rdy;
        if (rdy) begin
            sb_d[`FPC_SB_ARRAY_IDLE] = array_idle;
            sb_d[`FPC_SB_FAIL] = fail_q;
            sb_d[`FPC_SB_PRIOR_OP_FAILED] = prior_op_failed_q && !first_q;
        end
    end

    // software port: control write, status read, unmapped reads zero
    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = 32'h0000_0000;
        if (reg_we && reg_addr == `FPC_OFS_CTRL) begin
            ctrl_d = reg_wdata[2:0];
        end
        if (reg_re) begin
            case (reg_addr)
                `FPC_OFS_CTRL: rdata_d = {29'h0000_0000, ctrl_q};
                `FPC_OFS_STATUS: rdata_d = {20'h0_0000, 4'(state_q), sb_d};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // all state registers except the write protect synchronizer flops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= S_IDLE; op_q <= OP_PROG; pend_q <= PEND_FINAL;
            acnt_q <= 3'h0; fcnt_q <= 3'h0; cacc_q <= 16'h0000;
            row_q <= 24'h00_0000; arow_q <= 24'h00_0000;
            col_q <= '0; rcol_q <= '0; clr_q <= '0;
            hbank_q <= 1'b0; abank_q <= 1'b0; rdcond_q <= 1'b0; dval_q <= 1'b0;
            abusy_q <= 1'b0; aprog_q <= 1'b0; areq_q <= 1'b0;
            fail_q <= 1'b0; prior_op_failed_q <= 1'b0; first_q <= 1'b1; cseq_q <= 1'b0;
            ctrl_q <= `FPC_CTRL_RESET; rdata_q <= 32'h0000_0000; sb_q <= 8'h00;
        end else begin
            state_q <= state_d; op_q <= op_d; pend_q <= pend_d;
            acnt_q <= acnt_d; fcnt_q <= fcnt_d; cacc_q <= cacc_d;
            row_q <= row_d; arow_q <= arow_d;
            col_q <= col_d; rcol_q <= rcol_d; clr_q <= clr_d;
            hbank_q <= hbank_d; abank_q <= abank_d; rdcond_q <= rdcond_d; dval_q <= dval_d;
            abusy_q <= abusy_d; aprog_q <= aprog_d; areq_q <= areq_d;
            fail_q <= fail_d; prior_op_failed_q <= prior_op_failed_d; first_q <= first_d; cseq_q <= cseq_d;
            ctrl_q <= ctrl_d; rdata_q <= rdata_d; sb_q <= sb_d;
        end
    end

    assign dout_data = hdata;
    assign dout_valid = dval_q;
    assign status_byte = sb_q;
    assign arr_req = areq_q;
    assign arr_is_prog = aprog_q;
    assign arr_row = arow_q;
    assign reg_rdata = rdata_q;

    // refused at elaboration: the column counters wrap on a power-of-two page
    if (PAGE_BYTES < 4 || PAGE_BYTES > 65536 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0) begin : g_size_chk
        $error("PAGE_BYTES must be a power of two from 4 to 65536");
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence seq_flush_start;
        state_q == S_LOAD && cmd_valid && cmd_code == `FPC_CMD_FLUSH && ctrl_q[`FPC_CTRL_SMALL_BIT];
    endsequence
    sequence seq_flush_body;
        !rdy [*4] ##1 rdy;
    endsequence

    chk_fail_stable: assert property (rdy && $past(rdy) && array_idle && $past(array_idle) |-> $stable(fail_q))
        else $error("fail bit moved while ready");
    chk_cache_overlap: assert property (state_q == S_WAIT && pend_q == PEND_CACHE && !abusy_q
        |=> areq_q && rdy && hbank_q != $past(hbank_q))
        else $error("cache program did not overlap");
    chk_final_drain: assert property ($rose(rdy) && $past(state_q) == S_BUSY |-> array_idle)
        else $error("ready before array drained");
    chk_fail_capture: assert property (arr_done && abusy_q && aprog_q |=> fail_q == $past(arr_fail))
        else $error("fail bit missed result");
    chk_first_mask: assert property (first_q |-> ##1 !sb_q[`FPC_SB_PRIOR_OP_FAILED])
        else $error("prior fail shown on first op");
    chk_busy_mask: assert property (!rdy |=> sb_q[5:0] == 6'h00)
        else $error("status low bits shown while busy");
    chk_array_idle_clear: assert property (areq_q |-> !array_idle)
        else $error("array idle during operation");
    chk_rcol_move: assert property (state_q == S_RCOL_CF && cmd_valid && cmd_code == `FPC_CMD_RCOL_CF
        |=> rcol_q == $past(cacc_q[AW-1:0]))
        else $error("read column not moved");
    chk_flush_len: assert property (seq_flush_start |=> seq_flush_body)
        else $error("flush length wrong");
    chk_one_buffer: assert property (areq_q && !aprog_q |-> abank_q == hbank_q)
        else $error("copyback read used other buffer");
    chk_clear_gate: assert property (state_q == S_CLEAR |-> ctrl_q[`FPC_CTRL_CLR_BIT] && op_q == OP_PROG)
        else $error("clear without enhancement");
    chk_prog_row: assert property (areq_q |-> arr_row == $past(row_q))
        else $error("array row not the given row");
endmodule

`default_nettype wire

// [hdl/fpc_regs.svh]
// constants of the flash program/copyback sequencer: command codes,
// register offsets, field positions, reset values and counts.
// assumes nothing; included by bare name wherever the values are needed.
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// command opcodes seen on the command cycles
`define FPC_CMD_PROG 8'h80
`define FPC_CMD_PROG_ALT 8'h85
`define FPC_CMD_CONFIRM 8'h10
`define FPC_CMD_CACHE 8'h15
`define FPC_CMD_FLUSH 8'h11
`define FPC_CMD_READ 8'h00
`define FPC_CMD_CB_READ 8'h35
`define FPC_CMD_RCOL 8'h05
`define FPC_CMD_RCOL_CF 8'hE0

// register offsets on the software port
`define FPC_OFS_CTRL 4'h0
`define FPC_OFS_STATUS 4'h4

// control register fields and reset value
`define FPC_CTRL_CLR_BIT 0
`define FPC_CTRL_SMALL_BIT 1
`define FPC_CTRL_CACHE_BIT 2
`define FPC_CTRL_RESET 3'h6

// status byte field positions
`define FPC_SB_FAIL 0
`define FPC_SB_PRIOR_OP_FAILED 1
`define FPC_SB_ARRAY_IDLE 5
`define FPC_SB_RDY 6
`define FPC_SB_WP 7

// address cycles: two column bytes then three row bytes, low byte first
`define FPC_ADDR_LAST 3'h4
`define FPC_RCOL_LAST 3'h1
// cycles spent flushing the data pipeline on the flush command
`define FPC_FLUSH_CYC 3'h4
// fill value of a cleared page register
`define FPC_CLEAR_BYTE 8'hFF

`endif

// [sim/fpc_array_model.sv]
// behavioural array engine facing the sequencer's array port.
// assumes one page per request and a page register read latency of one cycle.
`default_nettype none

module fpc_array_model #(
    parameter int PB = 16
) (
    input wire logic clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic arr_req, // operation start
    input wire logic arr_is_prog, // program, else read
    input wire logic [7:0] arr_rdata, // page byte, one cycle late
    input wire logic fail_en, // next program reports failure
    output logic [$clog2(PB)-1:0] arr_addr, // column walk
    output logic arr_we, // fetched byte strobe
    output logic [7:0] arr_wdata, // fetched byte
    output logic arr_done, // operation end
    output logic arr_fail // failure, with done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] page_q [PB];
    logic busy_q, prog_q, fail_q;
    int cnt_q;

    // walk the page; capture lags the address by two edges because of the read flop
    always @(posedge clk) begin
        arr_done <= 1'b0;
        arr_we <= 1'b0;
        arr_fail <= !arr_fail; // only meaningful beside done
        arr_wdata <= ~arr_wdata;
        if (!rstn) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
        end else if (arr_req) begin
            busy_q <= 1'b1;
            cnt_q <= 0;
            prog_q <= arr_is_prog;
            fail_q <= fail_en;
        end else if (busy_q) begin
            if (prog_q && cnt_q >= 2 && cnt_q <= PB + 1) page_q[cnt_q-2] <= arr_rdata;
            if (cnt_q == PB + 1) begin
                busy_q <= 1'b0;
                arr_done <= 1'b1;
                arr_fail <= fail_q & prog_q;
            end else begin
                arr_addr <= cnt_q[$clog2(PB)-1:0];
                arr_we <= !prog_q && cnt_q < PB;
                arr_wdata <= 8'hA0 ^ cnt_q[7:0];
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule

`default_nettype wire

// [sim/fpc_program_seq_test.sv]
// bench of the program/copyback sequencer: reset and register cases, then a
// table of program cases, then hand-written cache, copyback and protect cases.
// assumes the array model at the array port; single 100 MHz clock.
`default_nettype none

module fpc_program_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PB = 16;
    typedef struct {logic [2:0] ctrl; logic fail; int n; logic [7:0] sb; logic [7:0] last;} fpc_row_t;
    fpc_row_t rows [2] = '{'{3'h6, 1'b0, 16, 8'hE0, 8'h4F}, '{3'h7, 1'b1, 1, 8'hE1, 8'hFF}};
    logic clk, rstn, cmd_valid, addr_valid, din_valid, dout_req, wp_n_pin, reg_we, reg_re, fail_en;
    logic load_ready, dout_valid, arr_req, arr_is_prog, arr_we, arr_done, arr_fail;
    logic [7:0] cmd_code, addr_byte, din, dout_data, status_byte, arr_rdata, arr_wdata;
    logic [3:0] reg_addr, arr_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] arr_row;
    int mismatches = 0;
    int num_checks = 0;

    fpc_program_seq #(.PAGE_BYTES(PB)) fpc_program_seq_i (.clk, .rstn, .cmd_valid, .cmd_code, .addr_valid,
        .addr_byte, .din_valid, .din, .load_ready, .dout_req, .dout_data, .dout_valid, .wp_n_pin, .status_byte,
        .arr_req, .arr_is_prog, .arr_row, .arr_addr, .arr_rdata, .arr_we, .arr_wdata, .arr_done, .arr_fail,
        .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
    fpc_array_model #(.PB(PB)) fpc_array_model_i (.clk, .rstn, .arr_req, .arr_is_prog, .arr_rdata, .fail_en,
        .arr_addr, .arr_we, .arr_wdata, .arr_done, .arr_fail);

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one host cycle: 0 command, 1 address, 2 data; a gap edge keeps strobes single
    task automatic send(input int k, input logic [7:0] b);
        @(posedge clk);
        cmd_valid <= (k == 0);
        addr_valid <= (k == 1);
        din_valid <= (k == 2);
        cmd_code <= b;
        addr_byte <= b;
        din <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
        addr_valid <= 1'b0;
        din_valid <= 1'b0;
    endtask

    task automatic addr5(input logic [7:0] col, input logic [23:0] row);
        logic [39:0] a;
        a = {row, 8'h00, col};
        for (int i = 0; i < 5; i++) send(1, a[8*i+:8]);
    endtask

    // waits out a possible page clear before loading data
    task automatic prog(input logic [7:0] op, input logic [7:0] col, input logic [23:0] row, input int n,
                        input logic [7:0] base, input logic [7:0] fin);
        send(0, op);
        addr5(col, row);
        repeat (PB + 4) @(posedge clk);
        #1 chk("load_ready", load_ready, 1);
        for (int k = 0; k < n; k++) send(2, base + 8'(k));
        send(0, fin);
    endtask

    // host polls ready before looking at the other bits
    task automatic wait_ready();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 400 && status_byte[6] !== 1'b1; i++) @(posedge clk);
        #1;
        chk("ready_poll", status_byte[6], 1);
    endtask

    task automatic rd_byte(input logic [7:0] exp);
        @(posedge clk);
        dout_req <= 1'b1;
        @(posedge clk);
        dout_req <= 1'b0;
        #1;
        chk("dout_valid", dout_valid, 1);
        chk("dout_data", dout_data, exp);
        @(posedge clk);
        #1 chk("dout_pulse", dout_valid, 0);
    endtask

    // read column change; setup delay honoured before any output
    task automatic rcol(input logic [7:0] col);
        send(0, 8'h05);
        send(1, col);
        send(1, 8'h00);
        send(0, 8'hE0);
        repeat (2) @(posedge clk);
    endtask

    task automatic reg_acc(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_we <= we;
        reg_re <= !we;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        reg_re <= 1'b0;
        #1;
        if (!we) chk("reg_rdata", reg_rdata, d);
    endtask

    // watchdog, far beyond the expected run
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    initial begin
        {cmd_valid, addr_valid, din_valid, dout_req, reg_we, reg_re, fail_en} = '0;
        {cmd_code, addr_byte, din, reg_addr, reg_wdata} = '0;
        wp_n_pin = 1'b1;
        rstn = 1'b0;
        repeat (19) @(posedge clk);
        #1 chk("status_in_reset", status_byte, 8'h00);
        @(posedge clk) rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("status_after_reset", status_byte, 8'hE0);
        reg_acc(0, 4'h0, 32'h0000_0006);
        reg_acc(1, 4'hC, 32'hFFFF_FFFF);
        reg_acc(0, 4'h0, 32'h0000_0006);
        reg_acc(0, 4'h8, 32'h0000_0000);
        reg_acc(0, 4'h4, 32'h0000_00E0);
        foreach (rows[i]) begin
            reg_acc(1, 4'h0, {29'h0, rows[i].ctrl});
            fail_en <= rows[i].fail;
            prog(8'h80, 8'h00, 24'h030201 + 24'(i), rows[i].n, 8'h40, 8'h10);
            wait_ready();
            chk("prog_status", status_byte, rows[i].sb);
            chk("prog_last_byte", fpc_array_model_i.page_q[PB-1], rows[i].last);
            chk("prog_row", arr_row, 24'h030201 + 24'(i));
        end
        // cache program: first page fails in the background, final page passes
        reg_acc(1, 4'h0, 32'h0000_0006);
        fail_en <= 1'b1;
        prog(8'h80, 8'h00, 24'h000200, 16, 8'h10, 8'h15);
        wait_ready();
        fail_en <= 1'b0;
        prog(8'h80, 8'h00, 24'h000201, 16, 8'h20, 8'h10);
        wait_ready();
        chk("cache_status", status_byte, 8'hE2);
        chk("cache_last_byte", fpc_array_model_i.page_q[PB-1], 8'h2F);
        // copyback with read-out, small move, flush and final program
        send(0, 8'h00);
        addr5(8'h02, 24'h000104);
        send(0, 8'h35);
        wait_ready();
        rd_byte(8'hA2);
        rcol(8'h05);
        rd_byte(8'hA5);
        prog(8'h85, 8'h03, 24'h000106, 1, 8'h3C, 8'h11);
        wait_ready();
        chk("flush_ready", status_byte[6], 1);
        rcol(8'h03);
        rd_byte(8'h3C);
        prog(8'h85, 8'h03, 24'h000106, 0, 8'h00, 8'h10);
        wait_ready();
        chk("cb_modified", fpc_array_model_i.page_q[3], 8'h3C);
        chk("cb_copied", fpc_array_model_i.page_q[4], 8'hA4);
        chk("cb_row", arr_row, 24'h000106);
        // cache off: the cache opcode must act as a final confirm, ready only once the array is idle
        reg_acc(1, 4'h0, 32'h0000_0002);
        prog(8'h80, 8'h00, 24'h000300, 1, 8'h55, 8'h15);
        wait_ready();
        chk("nocache_status", status_byte, 8'hE0);
        chk("nocache_byte", fpc_array_model_i.page_q[0], 8'h55);
        wp_n_pin <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("status_protect", status_byte, 8'h60);
        finish_test();
    end
endmodule

`default_nettype wire
